// [logic/bsfg_flags_gauge.sv]
// Primary status flags, temperature band and gauge readout of a battery charge monitor.
// Assumes command bytes and monitor events arrive from logic on the same clock.
//
// Operation
// - Read-only primary flag register at address 01h, seven monitored bits, bit 2 reads zero.
// - Charge status set while sense level exceeds threshold, cleared otherwise or on discharge.
// - Replaced flag sets on sense falling from above 2.25V, rising above 0.1V, reset.
// - Replaced flag clears when charge reaches learned capacity or charge after first warning.
// - Removed flag follows level: sense above 2.25V or below 0.1V.
// - Inaccurate flag sets on 64th charge or reset, clears on capacity update.
// - Valid discharge sets on discharge start at full, holds until update or clear.
// - Valid discharge clears when self-discharge count exceeds 4096.
// - Valid discharge clears after charge sustained for 256 available charge counts.
// - Valid discharge clears if first warning sets below 0 degrees.
// - First warning sets below 1.05V without overload, latched until valid charge.
// - First warning with display enabled blinks first segment at 4Hz.
// - Final warning sets below 0.95V without overload, latched until valid charge.
// - Final warning turns all segment drivers off.
// - Final warning releases the empty output for an external pull-up.
// - Read-only register 02h: temperature band high nibble, gauge low nibble.
// - Band code 0 below -30C, one per 10 degrees, 12 above 80C.
// - Gauge gives sixteenths 0 to 15 from charge, temperature, full reference.
// - Charge scaled by 1 above 0C, 0.75 down to -20C, 0.5 below.
// - Full and three-quarter scaling switch with 10 degree hysteresis.
// - Read command has bit 7 clear and address below; register byte returned.
// - Reset clears valid discharge and sets inaccurate and replaced flags.
`include "bsfg_map.svh"

module bsfg_flags_gauge #(
    parameter int BLINK_HALF_CYCLES = `BSFG_BLINK_CYCLES
) (
    input  wire logic                 clk,
    input  wire logic                 reset_n,
    input  wire logic                 ce,
    input  wire logic                 soft_reset,
    input  wire logic                 cmd_valid,
    input  wire bsfg_pkg::bsfg_byte_t command_byte,
    output logic                      rd_valid,
    output logic                      rd_hit,
    output bsfg_pkg::bsfg_byte_t      rd_data,
    input  wire logic                 sense_above_threshold,
    input  wire logic                 discharge_active,
    input  wire logic                 valid_charge,
    input  wire logic                 charge_count_inc,
    input  wire logic                 sense_above_max,
    input  wire logic                 sense_below_min,
    input  wire logic                 sense_below_first,
    input  wire logic                 sense_below_final,
    input  wire logic                 overload_flag,
    input  wire logic                 capacity_update,
    input  wire logic [15:0]          self_discharge_counter,
    input  wire logic [15:0]          available_charge_count,
    input  wire bsfg_pkg::bsfg_byte_t learned_capacity,
    input  wire bsfg_pkg::bsfg_byte_t programmed_capacity,
    input  wire logic                 use_programmed,
    input  wire logic signed [7:0]    temperature_c,
    input  wire logic                 display_enable,
    output logic [4:0]                display_segment,
    output logic                      empty_out,
    output logic                      empty_oe
);
    import bsfg_pkg::*;

    // ------------------------------------------------------------
    // Flag state
    // ------------------------------------------------------------
    logic        charge_status_flag;
    logic        battery_replaced_flag;
    logic        battery_removed_flag;
    logic        capacity_inaccurate_flag;
    logic        valid_discharge_flag;
    logic        first_end_discharge_flag;
    logic        final_end_discharge_flag;
    logic        above_max_q;
    logic        below_min_q;
    logic        discharge_q;
    logic [7:0]  charge_tally;
    logic [8:0]  sustain_count;

    wire         at_full       = available_charge_count[15:8] == learned_capacity;
    wire         freezing      = temperature_c < `BSFG_COLD_ENTER_C;
    wire         warn1_event   = sense_below_first && !overload_flag;
    wire         warnf_event   = sense_below_final && !overload_flag;
    wire         warn1_rise    = warn1_event && !first_end_discharge_flag;
    wire         tally_next    = charge_tally != `BSFG_TALLY_SATURATE;
    wire         inacc_event   = valid_charge && charge_tally == `BSFG_INACC_CHARGES - 8'h01;
    wire         sustain_done  = sustain_count >= `BSFG_SUSTAIN_COUNTS;
    wire         replaced_set  = (above_max_q && !sense_above_max)
                               || (below_min_q && !sense_below_min) || soft_reset;
    wire         replaced_clr  = (charge_count_inc && at_full)
                               || (valid_charge && first_end_discharge_flag);
    wire         vdis_set      = discharge_active && !discharge_q && at_full;
    wire         vdis_clr      = capacity_update || soft_reset || sustain_done
                               || self_discharge_counter > `BSFG_SELF_DIS_LIMIT
                               || (warn1_rise && freezing);

    // The set term is listed last so an event in the clearing cycle survives; a valid discharge start loses to a soft reset.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            charge_status_flag       <= 1'b0;
            battery_replaced_flag    <= 1'b1;
            battery_removed_flag     <= 1'b0;
            capacity_inaccurate_flag <= 1'b1;
            valid_discharge_flag     <= 1'b0;
            first_end_discharge_flag <= 1'b0;
            final_end_discharge_flag <= 1'b0;
            above_max_q              <= 1'b0;
            below_min_q              <= 1'b0;
            discharge_q              <= 1'b0;
        end else if (ce) begin
            charge_status_flag   <= sense_above_threshold && !discharge_active;
            battery_removed_flag <= sense_above_max || sense_below_min;
            above_max_q          <= sense_above_max;
            below_min_q          <= sense_below_min;
            discharge_q          <= discharge_active;
            if (replaced_clr)
                battery_replaced_flag <= 1'b0;
            if (replaced_set)
                battery_replaced_flag <= 1'b1;
            if (capacity_update)
                capacity_inaccurate_flag <= 1'b0;
            if (inacc_event || soft_reset)
                capacity_inaccurate_flag <= 1'b1;
            if (vdis_clr)
                valid_discharge_flag <= 1'b0;
            if (vdis_set && !soft_reset)
                valid_discharge_flag <= 1'b1;
            if (valid_charge)
                first_end_discharge_flag <= 1'b0;
            if (warn1_event)
                first_end_discharge_flag <= 1'b1;
            if (valid_charge)
                final_end_discharge_flag <= 1'b0;
            if (warnf_event)
                final_end_discharge_flag <= 1'b1;
        end
    end

    // Charge tally saturates and restarts on each capacity update.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            charge_tally  <= 8'h00;
            sustain_count <= 9'h000;
        end else if (ce) begin
            if (capacity_update || soft_reset)
                charge_tally <= 8'h00;
            else if (valid_charge && tally_next)
                charge_tally <= charge_tally + 8'h01;
            if (!sense_above_threshold || discharge_active || sustain_done)
                sustain_count <= 9'h000;
            else if (charge_count_inc)
                sustain_count <= sustain_count + 9'h001;
        end
    end

    // ------------------------------------------------------------
    // Temperature band and cold correction
    // ------------------------------------------------------------
    logic [`BSFG_TEMP_BANDS-1:0] temp_above;
    bsfg_scale_e                 scale;
    bsfg_scale_e                 next_scale;

    function automatic bsfg_nib_t count_ones(input logic [`BSFG_TEMP_BANDS-1:0] v);
        bsfg_nib_t n;
        n = 4'h0;
        for (int i = 0; i < `BSFG_TEMP_BANDS; i++)
            n = n + {3'b000, v[i]};
        return n;
    endfunction

    for (genvar k = 0; k < `BSFG_TEMP_BANDS; k++) begin : g_band
        localparam logic signed [7:0] EDGE = 8'(`BSFG_TEMP_BASE_C + `BSFG_TEMP_STEP_C * k);
        assign temp_above[k] = temperature_c > EDGE;
    end

    wire bsfg_nib_t temperature_band_code = count_ones(temp_above);

    // Hysteresis only around 0C; the -20C step has none, as the cold table has none there.
    always_comb begin
        next_scale = scale;
        unique case (scale)
            BSFG_SCALE_FULL: if (freezing) next_scale = BSFG_SCALE_3Q;
            BSFG_SCALE_3Q: begin
                if (temperature_c < `BSFG_FREEZE_C)
                    next_scale = BSFG_SCALE_HALF;
                else if (temperature_c >= `BSFG_COLD_LEAVE_C)
                    next_scale = BSFG_SCALE_FULL;
            end
            BSFG_SCALE_HALF: if (temperature_c >= `BSFG_FREEZE_C) next_scale = BSFG_SCALE_3Q;
            default: next_scale = BSFG_SCALE_FULL;
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n)
            scale <= BSFG_SCALE_FULL;
        else if (ce)
            scale <= next_scale;
    end

    // ------------------------------------------------------------
    // Gauge divider: four restoring steps give sixteenths
    // ------------------------------------------------------------
    logic [16:0] div_rem;
    bsfg_nib_t   div_q;
    logic [2:0]  div_step;
    logic        div_sat;
    bsfg_nib_t   gauge_value_field;

    wire [15:0] scaled_charge = (scale == BSFG_SCALE_FULL) ? available_charge_count :
                                (scale == BSFG_SCALE_3Q)
                                ? available_charge_count - {2'b00, available_charge_count[15:2]}
                                : {1'b0, available_charge_count[15:1]};
    wire [7:0]  full_ref   = use_programmed ? programmed_capacity : learned_capacity;
    wire [16:0] divisor    = {1'b0, full_ref, 8'h00};
    wire [16:0] rem_shift  = {div_rem[15:0], 1'b0};
    wire        step_fits  = rem_shift >= divisor;
    wire bsfg_nib_t q_next = {div_q[2:0], step_fits};

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            div_rem           <= 17'h00000;
            div_q             <= 4'h0;
            div_step          <= 3'h0;
            div_sat           <= 1'b0;
            gauge_value_field <= 4'h0;
        end else if (ce) begin
            if (div_step == 3'h0) begin
                div_rem  <= {1'b0, scaled_charge};
                div_q    <= 4'h0;
                div_sat  <= {1'b0, scaled_charge} >= divisor;
                div_step <= 3'h1;
            end else begin
                div_rem  <= step_fits ? rem_shift - divisor : rem_shift;
                div_q    <= q_next;
                div_step <= (div_step == `BSFG_DIV_LAST_STEP) ? 3'h0 : div_step + 3'h1;
                if (div_step == `BSFG_DIV_LAST_STEP)
                    gauge_value_field <= div_sat ? `BSFG_GAUGE_FULL : q_next;
            end
        end
    end

    // ------------------------------------------------------------
    // Register readout
    // ------------------------------------------------------------
    wire bsfg_byte_t primary_status_flags = {charge_status_flag, battery_replaced_flag,
        battery_removed_flag, capacity_inaccurate_flag, valid_discharge_flag,
        1'b0, first_end_discharge_flag, final_end_discharge_flag};
    wire bsfg_byte_t temperature_and_gauge = {temperature_band_code, gauge_value_field};
    wire        cmd_read  = cmd_valid && !command_byte[`BSFG_CMD_WRITE_BIT];
    wire        hit_flags = command_byte[6:0] == `BSFG_ADDR_FLAGS;
    wire        hit_tg    = command_byte[6:0] == `BSFG_ADDR_TEMPGAUGE;
    wire bsfg_byte_t sel  = hit_flags ? primary_status_flags :
                            hit_tg ? temperature_and_gauge : 8'h00;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rd_valid <= 1'b0;
            rd_hit   <= 1'b0;
            rd_data  <= 8'h00;
        end else if (ce) begin
            rd_valid <= cmd_read;
            rd_hit   <= cmd_read && (hit_flags || hit_tg);
            if (cmd_read)
                rd_data <= sel;
        end
    end

    // ------------------------------------------------------------
    // Display and empty indicator
    // ------------------------------------------------------------
    logic [22:0] blink_count;
    logic        blink_phase;
    logic [4:0]  bar;

    for (genvar s = 0; s < 5; s++) begin : g_seg
        assign bar[s] = gauge_value_field >= 4'(3 * s + 1);
    end

    wire [4:0] seg_next = (final_end_discharge_flag || !display_enable) ? 5'h00 :
                          {bar[4:1], first_end_discharge_flag ? blink_phase : bar[0]};

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            blink_count     <= 23'h000000;
            blink_phase     <= 1'b0;
            display_segment <= 5'h00;
            empty_out       <= 1'b0;
            empty_oe        <= 1'b1;
        end else if (ce) begin
            if (blink_count == 23'(BLINK_HALF_CYCLES - 1)) begin
                blink_count <= 23'h000000;
                blink_phase <= !blink_phase;
            end else begin
                blink_count <= blink_count + 23'h000001;
            end
            display_segment <= seg_next;
            empty_out       <= 1'b0;
            empty_oe        <= !final_end_discharge_flag;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    sequence read_flags_s;
        ce && cmd_valid && command_byte == {1'b0, `BSFG_ADDR_FLAGS};
    endsequence
    sequence answer_s;
        rd_valid && rd_hit;
    endsequence

    charge_follow_a: assert property (@(posedge clk) disable iff (!reset_n)
        ce && sense_above_threshold && !discharge_active |=> charge_status_flag)
        else $error("charge status did not follow sense level");
    removed_level_a: assert property (@(posedge clk) disable iff (!reset_n)
        ce && !sense_above_max && !sense_below_min |=> !battery_removed_flag)
        else $error("removed flag held without cause");
    warn_latch_a: assert property (@(posedge clk) disable iff (!reset_n)
        ce && first_end_discharge_flag && !valid_charge |=> first_end_discharge_flag)
        else $error("first warning dropped without charge");
    seg_off_a: assert property (@(posedge clk) disable iff (!reset_n)
        ce && final_end_discharge_flag |=> display_segment == 5'h00)
        else $error("segments lit during final warning");
    empty_rel_a: assert property (@(posedge clk) disable iff (!reset_n)
        ce && final_end_discharge_flag |=> !empty_oe && !empty_out)
        else $error("empty output still driven");
    flag_read_a: assert property (@(posedge clk) disable iff (!reset_n)
        read_flags_s |=> answer_s and rd_data[`BSFG_BIT_UNUSED] == 1'b0)
        else $error("flag read answer wrong");
    write_ign_a: assert property (@(posedge clk) disable iff (!reset_n)
        ce && cmd_valid && command_byte[`BSFG_CMD_WRITE_BIT] |=> !rd_valid && $stable(rd_data))
        else $error("write command produced an answer");
    inacc_clear_a: assert property (@(posedge clk) disable iff (!reset_n)
        ce && capacity_update && !valid_charge && !soft_reset |=> !capacity_inaccurate_flag)
        else $error("inaccurate flag not cleared by update");
    vdis_limit_a: assert property (@(posedge clk) disable iff (!reset_n)
        ce && self_discharge_counter > `BSFG_SELF_DIS_LIMIT && !vdis_set |=> !valid_discharge_flag)
        else $error("valid discharge kept past self-discharge limit");
endmodule

// [inc/bsfg_map.svh]
// Register map, field positions and timing counts of the status flag and gauge block.
// Assumes a 20 MHz core clock; included by the block itself.
`ifndef BSFG_MAP_SVH
`define BSFG_MAP_SVH
`define BSFG_ADDR_FLAGS      7'h01
`define BSFG_ADDR_TEMPGAUGE  7'h02
`define BSFG_CMD_WRITE_BIT   7
`define BSFG_BIT_CHARGE      7
`define BSFG_BIT_REPLACED    6
`define BSFG_BIT_REMOVED     5
`define BSFG_BIT_INACCURATE  4
`define BSFG_BIT_VALID_DIS   3
`define BSFG_BIT_UNUSED      2
`define BSFG_BIT_WARN_FIRST  1
`define BSFG_BIT_WARN_FINAL  0
`define BSFG_SELF_DIS_LIMIT  16'h1000
`define BSFG_SUSTAIN_COUNTS  9'h100
`define BSFG_INACC_CHARGES   8'h40
`define BSFG_TALLY_SATURATE  8'hff
`define BSFG_TEMP_BASE_C     (-30)
`define BSFG_TEMP_STEP_C     10
`define BSFG_TEMP_BANDS      12
`define BSFG_COLD_ENTER_C    8'sh00
`define BSFG_COLD_LEAVE_C    8'sh0a
`define BSFG_FREEZE_C        8'shec
`define BSFG_CLK_PERIOD_NS   50
`define BSFG_BLINK_HALF_NS   125000000
`define BSFG_BLINK_CYCLES    (`BSFG_BLINK_HALF_NS / `BSFG_CLK_PERIOD_NS)
`define BSFG_GAUGE_FULL      4'hf
`define BSFG_DIV_LAST_STEP   3'h4
`endif

// [inc/bsfg_pkg.sv]
// Types shared by the status flag and gauge block.
// Assumes bsfg_map.svh is on the include path.
package bsfg_pkg;
    typedef logic [7:0] bsfg_byte_t;
    typedef logic [3:0] bsfg_nib_t;
    // Cold correction state, Gray coded along full -> three quarter -> half.
    typedef enum logic [1:0] {
        BSFG_SCALE_FULL = 2'b00,
        BSFG_SCALE_3Q   = 2'b01,
        BSFG_SCALE_HALF = 2'b11
    } bsfg_scale_e;
endpackage

// [test/bsfg_host_model.sv]
// Host processor model: sends one command byte a call and collects the answer.
// Assumes the block answers a read one cycle after taking the command, on the same clock.
module bsfg_host_model (
    input  wire logic                 clk,
    output logic                      cmd_valid,
    output bsfg_pkg::bsfg_byte_t      command_byte,
    input  wire logic                 rd_valid,
    input  wire logic                 rd_hit,
    input  wire bsfg_pkg::bsfg_byte_t rd_data
);
    timeunit 1ns;
    timeprecision 100ps;
    import bsfg_pkg::*;

    initial begin
        cmd_valid = 1'b0;
        command_byte = 8'h00;
    end

    // Bit 7 clear reads, set writes; the low seven bits carry the address.
    task automatic send(input bsfg_byte_t cmd, output logic [9:0] ans);
        @(posedge clk);
        #1;
        cmd_valid = 1'b1;
        command_byte = cmd;
        @(posedge clk);
        #1;
        cmd_valid = 1'b0;
        // The idle byte is inverted so a stale command can never pass for a fresh one.
        command_byte = ~cmd;
        ans = {rd_valid, rd_hit, rd_data};
    endtask
endmodule

// [test/tb.sv]
// Self-checking bench of the status flag and gauge block.
// Assumes the host model drives the command port and the bench drives all monitor inputs.
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    import bsfg_pkg::*;

    logic              clk, reset_n, ce, srst, cvld, rvld, rhit, thr, dis, vchg, cinc, amax, bmin;
    logic              bedv1, bedvf, ovl, cupd, upg, den, eo, eoe;
    logic [15:0]       sdc, avail;
    logic signed [7:0] temp;
    logic [4:0]        seg;
    bsfg_byte_t        cbyte, rdat, learned, prog_cap;
    logic [9:0]        ans;
    logic              b;
    int                bad_count, check_count, cyc;
    logic signed [7:0] temps [7] = '{25, -10, -25, -35, 5, 10, 85};
    bsfg_byte_t        gexp [7] = '{8'h68, 8'h26, 8'h14, 8'h04, 8'h46, 8'h48, 8'hc8};

    bsfg_flags_gauge #(.BLINK_HALF_CYCLES(4)) i_bsfg_flags_gauge (
        .clk(clk), .reset_n(reset_n), .ce(ce), .soft_reset(srst), .cmd_valid(cvld), .command_byte(cbyte),
        .rd_valid(rvld), .rd_hit(rhit), .rd_data(rdat), .sense_above_threshold(thr), .discharge_active(dis),
        .valid_charge(vchg), .charge_count_inc(cinc), .sense_above_max(amax), .sense_below_min(bmin),
        .sense_below_first(bedv1), .sense_below_final(bedvf), .overload_flag(ovl), .capacity_update(cupd),
        .self_discharge_counter(sdc), .available_charge_count(avail), .learned_capacity(learned),
        .programmed_capacity(prog_cap), .use_programmed(upg), .temperature_c(temp), .display_enable(den),
        .display_segment(seg), .empty_out(eo), .empty_oe(eoe));

    bsfg_host_model i_bsfg_host_model (
        .clk(clk), .cmd_valid(cvld), .command_byte(cbyte), .rd_valid(rvld), .rd_hit(rhit), .rd_data(rdat));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // A hang is cut short at 6000 cycles, well above the roughly 700 cycles the sequence needs.
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            bad_count++;
            complete_run();
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic pulse(ref logic s);
        s = 1'b1;
        tick(1);
        s = 1'b0;
        tick(1);
    endtask

    task automatic rd(input bsfg_byte_t cmd, input bsfg_byte_t exp);
        i_bsfg_host_model.send(cmd, ans);
        check({6'h00, ans}, {8'h03, exp});
    endtask

    task automatic complete_run();
        $display("checks=%0d mismatches=%0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    initial begin
        {reset_n, srst, thr, dis, vchg, cinc, amax, bmin, bedv1, bedvf, ovl, cupd, upg} = '0;
        {ce, den} = 2'b11;
        sdc = 16'h0000;
        avail = 16'h0800;
        learned = 8'h10;
        prog_cap = 8'h20;
        temp = 8'sd25;
        {bad_count, check_count, cyc} = '0;
        repeat (16) @(posedge clk);
        #1;
        reset_n = 1'b1;
        tick(12);
        check({eoe, eo}, 16'h0002);
        rd(8'h01, 8'h50);
        i_bsfg_host_model.send(8'h81, ans);
        check({15'h0000, ans[9]}, 16'h0000);
        i_bsfg_host_model.send(8'h82, ans);
        check({15'h0000, ans[9]}, 16'h0000);
        rd(8'h01, 8'h50);
        i_bsfg_host_model.send(8'h05, ans);
        check({6'h00, ans}, 16'h0200);
        tick(1);
        ce = 1'b0;
        i_bsfg_host_model.send(8'h01, ans);
        check({15'h0000, ans[9]}, 16'h0000);
        ce = 1'b1;
        $display("test access done");
        amax = 1'b1;
        tick(3);
        rd(8'h01, 8'h70);
        amax = 1'b0;
        bmin = 1'b1;
        tick(3);
        rd(8'h01, 8'h70);
        bmin = 1'b0;
        tick(3);
        rd(8'h01, 8'h50);
        thr = 1'b1;
        tick(3);
        rd(8'h01, 8'hd0);
        dis = 1'b1;
        tick(3);
        rd(8'h01, 8'h50);
        {thr, dis} = 2'b00;
        $display("test levels done");
        pulse(cupd);
        avail = 16'h1000;
        tick(1);
        dis = 1'b1;
        tick(3);
        rd(8'h01, 8'h48);
        sdc = 16'h1000;
        tick(3);
        rd(8'h01, 8'h48);
        sdc = 16'h1001;
        tick(3);
        rd(8'h01, 8'h40);
        {sdc, dis} = '0;
        tick(1);
        dis = 1'b1;
        tick(3);
        rd(8'h01, 8'h48);
        pulse(srst);
        tick(1);
        rd(8'h01, 8'h50);
        dis = 1'b0;
        pulse(cupd);
        repeat (63) pulse(vchg);
        rd(8'h01, 8'h40);
        pulse(vchg);
        tick(1);
        rd(8'h01, 8'h50);
        dis = 1'b1;
        tick(2);
        {thr, dis, cinc} = 3'b101;
        tick(255);
        cinc = 1'b0;
        rd(8'h01, 8'h98);
        pulse(cinc);
        rd(8'h01, 8'h90);
        {thr, amax} = 2'b01;
        tick(2);
        amax = 1'b0;
        tick(2);
        rd(8'h01, 8'h50);
        $display("test discharge done");
        avail = 16'h0800;
        {ovl, bedv1} = 2'b11;
        tick(3);
        rd(8'h01, 8'h50);
        ovl = 1'b0;
        tick(3);
        rd(8'h01, 8'h52);
        b = seg[0];
        tick(4);
        check({15'h0000, seg[0]}, {15'h0000, ~b});
        den = 1'b0;
        tick(2);
        check({11'h000, seg}, 16'h0000);
        den = 1'b1;
        bedvf = 1'b1;
        tick(3);
        rd(8'h01, 8'h53);
        check({seg, eoe}, 16'h0000);
        {bedv1, bedvf} = 2'b00;
        tick(3);
        rd(8'h01, 8'h53);
        pulse(vchg);
        tick(1);
        rd(8'h01, 8'h10);
        $display("test warnings done");
        avail = 16'h1000;
        temp = -8'sd5;
        tick(1);
        dis = 1'b1;
        tick(2);
        rd(8'h01, 8'h18);
        bedv1 = 1'b1;
        tick(2);
        rd(8'h01, 8'h12);
        {bedv1, dis} = 2'b00;
        pulse(vchg);
        avail = 16'h0800;
        for (int k = 0; k < 7; k++) begin
            temp = temps[k];
            tick(15);
            rd(8'h02, gexp[k]);
        end
        avail = 16'h1100;
        tick(15);
        rd(8'h02, 8'hcf);
        check({11'h000, seg}, 16'h001f);
        upg = 1'b1;
        tick(15);
        rd(8'h02, 8'hc8);
        $display("test gauge done");
        complete_run();
    end
endmodule
